// File: common/chan_parity_pkg.sv
package chan_parity_pkg;

   // Clock rate and the cycle count derived from a time in nanoseconds.
   localparam int CLK_MHZ = 125;

   // Least times round up to whole cycles, never below one.
   function automatic int ceil_cyc(input int ns);
      int c;
      c = (ns * CLK_MHZ + 999) / 1000;
      return (c < 1) ? 1 : c;
   endfunction : ceil_cyc

   // Least command pulse width of a basic transfer.
   localparam int CMD_MIN_NS = 190;
   // Least time from address latch active to the write parity strobe.
   localparam int ADL_TO_DPV_NS = 40;
   // Least write data and parity setup ahead of the command strobe.
   localparam int WR_SETUP_NS = 15;
   // Least strobe hold after the command strobe ends, basic write.
   localparam int DPV_HOLD_NS = 20;
   // Least strobe hold after the command strobe ends, streaming write.
   localparam int DPV_HOLD_STREAM_NS = 40;
   // Least time the strobe stays driven inactive before release.
   localparam int DPV_RELEASE_NS = 20;
   // Passive recovery allowed before the read check result is used.
   localparam int READ_RECOVERY_NS = 90;

   localparam int CMD_CYC = ceil_cyc(CMD_MIN_NS);
   localparam int ADDR_CYC = (ceil_cyc(ADL_TO_DPV_NS) > ceil_cyc(WR_SETUP_NS)) ?
                             ceil_cyc(ADL_TO_DPV_NS) : ceil_cyc(WR_SETUP_NS);
   localparam int HOLD_CYC = ceil_cyc(DPV_HOLD_NS);
   localparam int HOLD_STREAM_CYC = ceil_cyc(DPV_HOLD_STREAM_NS);
   localparam int RELEASE_CYC = ceil_cyc(DPV_RELEASE_NS);
   localparam int RECOVERY_CYC = ceil_cyc(READ_RECOVERY_NS);

   // Width of the phase timer.
   localparam int TIMER_W = 6;

   // Parity sense on the data parity pins; 1 selects odd parity.
   localparam logic PARITY_ODD = 1'b1;

   localparam int LANES = 4;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,
      ST_ADDR    = 3'b001,
      ST_CMD     = 3'b010,
      ST_HOLD    = 3'b011,
      ST_RELEASE = 3'b100
   } phase_t;

endpackage : chan_parity_pkg

// File: rtl/lane_parity.sv
`timescale 1ns/1ns

// Per-lane parity for one 32-bit word and a mismatch check on the lanes
// that are in use for the transfer.
module lane_parity #(
   parameter int LANES = chan_parity_pkg::LANES
) (
   // Word and lane qualifiers
   input wire logic [LANES*8-1:0] data,
   input wire logic [LANES-1:0] lane_en,
   input wire logic [LANES-1:0] par_in,
   // Results
   output logic [LANES-1:0] par,
   output logic err
);

   logic [LANES-1:0] miss;

   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : g_lane
         // One parity bit per lane, computed over that lane only.
         assign par[g] = (^data[g*8 +: 8]) ^ chan_parity_pkg::PARITY_ODD;
         assign miss[g] = lane_en[g] & (par[g] != par_in[g]);
      end
   endgenerate

   assign err = |miss;

endmodule : lane_parity

// File: rtl/parity_master.sv
`timescale 1ns/1ns

// Operation
// [RULE_01] Only the data source drives parity-valid strobe.
// [RULE_02] Parity bits accompany data on every cycle; the code registers them in ST_ADDR, one cycle after write data is driven.
// [RULE_03] Parity matters only on lanes in use.
// [RULE_04] 64-bit streaming: address parity carries upper parity.
// [RULE_05] Slave read strobe within 60/160 ns.
// [RULE_06] Async read: strobe active by ready.
// [RULE_07] Slave read strobe inactive, then released.
// [RULE_08] Master checks read parity; slave never told.
// [RULE_09] Write strobe within 20 ns of command.
// [RULE_10] Write strobe 40 ns after latch.
// [RULE_11] Write data and parity 15 ns before command.
// [RULE_12] Write strobe held 20 ns after command.
// [RULE_13] Wait 90 ns recovery before read check.
// [RULE_14] Slave pulses channel check on write error.
// [RULE_15] DMA asserts terminal count after channel check.
// [RULE_16] Streaming write strobe held 40 ns, until sampled.
// [RULE_17] Burst on streaming; released after strobe inactive.
// [RULE_18] Replicated or steered bytes carry parity too.
// [RULE_19] Drive strobe inactive before releasing it.
// [RULE_20] Read parity error posts an exception.
// [RULE_21] DMA read error records status, terminal count.
// [RULE_22] Parity enable resets disabled; disabled means no parity.
// [RULE_23] Clear channel check by writing one.
// [RULE_24] Parity bit n covers byte lane n.
module parity_master #(
   parameter int DW = 32
) (
   input wire logic clk,
   input wire logic sys_rst,
   // Configuration
   input wire logic cfg_we,
   input wire logic cfg_parity_en,
   input wire logic cfg_dma_mode,
   // Transfer request
   input wire logic req,
   input wire logic req_write,
   input wire logic req_stream,
   input wire logic req_wide,
   input wire logic [3:0] req_be_n,
   input wire logic [DW-1:0] req_addr,
   input wire logic [DW-1:0] req_wdata,
   input wire logic [DW-1:0] req_wdata_hi,
   input wire logic status_clear,
   // Transfer answer
   output logic busy,
   output logic done,
   output logic [DW-1:0] rdata,
   output logic [DW-1:0] rdata_hi,
   output logic read_parity_err,
   output logic check_seen,
   output logic exception_post,
   output logic parity_en,
   // Channel control
   output logic address_latch_n,
   output logic cmd_n,
   output logic burst_n,
   output logic terminal_count_n,
   output logic [3:0] byte_enables_n,
   input wire logic slot_ready,
   input wire logic channel_check_n,
   // Channel address bus and its parity
   output logic [DW-1:0] addr_out,
   output logic [3:0] addr_parity_out,
   output logic addr_oe,
   input wire logic [DW-1:0] addr_in,
   input wire logic [3:0] addr_parity_in,
   output logic addr_parity_valid_n,
   // Channel data bus and its parity
   output logic [DW-1:0] data_out,
   output logic [3:0] data_parity_bits_out,
   output logic data_oe,
   input wire logic [DW-1:0] data_in,
   input wire logic [3:0] data_parity_bits_in,
   // Parity-valid strobe, three-state
   output logic data_parity_valid_n_out,
   output logic data_parity_valid_n_oe,
   input wire logic data_parity_valid_n_in
);

   chan_parity_pkg::phase_t state_reg, state_next;
   logic [chan_parity_pkg::TIMER_W-1:0] timer_reg, timer_next;
   logic wr_reg, stream_reg, wide_reg, tc_pend_reg;
   logic [3:0] lane_en;
   logic [3:0] par_lo, par_hi;
   logic err_lo, err_hi;
   logic [DW-1:0] chk_lo, chk_hi, wdata_hi_reg;
   logic timer_zero, take, cmd_end, rd_strobe, rd_err, channel_check_n_now;
   logic [chan_parity_pkg::TIMER_W-1:0] hold_load;

   // Receiver checks only the lanes the byte enables mark valid.
   assign lane_en = ~byte_enables_n; // see [RULE_03]
   assign chk_lo = wr_reg ? data_out : data_in;
   assign chk_hi = !wr_reg ? addr_in : (wide_reg && state_reg == chan_parity_pkg::ST_ADDR &&
                   timer_zero) ? wdata_hi_reg : addr_out;

   // Parity is generated over all four lanes driven, so replicated bytes
   // are covered without knowing which lanes hold copies.
   lane_parity u_par_lo ( // see [RULE_24]
      .data(chk_lo),
      .lane_en(lane_en),
      .par_in(data_parity_bits_in),
      .par(par_lo),
      .err(err_lo)
   );

   lane_parity u_par_hi (
      .data(chk_hi),
      .lane_en(lane_en),
      .par_in(addr_parity_in),
      .par(par_hi),
      .err(err_hi)
   );

   assign timer_zero = (timer_reg == '0);
   assign take = (state_reg == chan_parity_pkg::ST_IDLE) && req;
   assign cmd_end = (state_reg == chan_parity_pkg::ST_CMD) && timer_zero && slot_ready;
   // Read data is checked only when the slave flagged parity as valid.
   assign rd_strobe = parity_en && !data_parity_valid_n_in; // see [RULE_08]
   assign rd_err = rd_strobe && (err_lo || (wide_reg && err_hi)); // see [RULE_08]
   assign channel_check_n_now = wr_reg && !channel_check_n &&
                     (state_reg == chan_parity_pkg::ST_CMD ||
                      state_reg == chan_parity_pkg::ST_HOLD);
   // Streaming writes hold longer so the slave can gate channel check.
   assign hold_load = !wr_reg ? chan_parity_pkg::TIMER_W'(chan_parity_pkg::RECOVERY_CYC - 1) :
                      stream_reg ?
                      chan_parity_pkg::TIMER_W'(chan_parity_pkg::HOLD_STREAM_CYC - 1) :
                      chan_parity_pkg::TIMER_W'(chan_parity_pkg::HOLD_CYC - 1);

   always_comb begin
      state_next = state_reg;
      timer_next = timer_zero ? timer_reg : timer_reg - 1'b1;
      unique case (state_reg)
         chan_parity_pkg::ST_IDLE: begin
            if (req) begin
               state_next = chan_parity_pkg::ST_ADDR;
               timer_next = chan_parity_pkg::TIMER_W'(chan_parity_pkg::ADDR_CYC - 1);
            end
         end
         chan_parity_pkg::ST_ADDR: begin
            if (timer_zero) begin
               state_next = chan_parity_pkg::ST_CMD;
               timer_next = chan_parity_pkg::TIMER_W'(chan_parity_pkg::CMD_CYC - 1);
            end
         end
         chan_parity_pkg::ST_CMD: begin
            if (cmd_end) begin
               state_next = chan_parity_pkg::ST_HOLD;
               timer_next = hold_load;
            end
         end
         chan_parity_pkg::ST_HOLD: begin
            if (timer_zero) begin
               state_next = wr_reg ? chan_parity_pkg::ST_RELEASE : chan_parity_pkg::ST_IDLE;
               timer_next = chan_parity_pkg::TIMER_W'(chan_parity_pkg::RELEASE_CYC - 1);
            end
         end
         chan_parity_pkg::ST_RELEASE: begin
            if (timer_zero) begin
               state_next = chan_parity_pkg::ST_IDLE;
            end
         end
         default: begin
            state_next = chan_parity_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_reg <= chan_parity_pkg::ST_IDLE;
         timer_reg <= '0;
      end else begin
         state_reg <= state_next;
         timer_reg <= timer_next;
      end
   end

   // Configuration comes up with parity disabled.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         parity_en <= 1'b0; // see [RULE_22]
         tc_pend_reg <= 1'b0;
      end else begin
         if (cfg_we) begin
            parity_en <= cfg_parity_en;
         end
         // A write check or read error is answered on the next DMA operation.
         if (cfg_dma_mode && (channel_check_n_now || (cmd_end && !wr_reg && rd_err))) begin
            tc_pend_reg <= 1'b1; // see [RULE_15] see [RULE_21]
         end else if (state_reg == chan_parity_pkg::ST_ADDR && timer_zero) begin
            tc_pend_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wr_reg <= 1'b0;
         stream_reg <= 1'b0;
         wide_reg <= 1'b0;
         wdata_hi_reg <= '0;
         busy <= 1'b0;
         address_latch_n <= 1'b1;
         cmd_n <= 1'b1;
         burst_n <= 1'b1;
         terminal_count_n <= 1'b1;
         byte_enables_n <= 4'hF;
         addr_out <= '0;
         addr_oe <= 1'b0;
         addr_parity_out <= 4'h0;
         addr_parity_valid_n <= 1'b1;
         data_out <= '0;
         data_oe <= 1'b0;
         data_parity_bits_out <= 4'h0;
         data_parity_valid_n_out <= 1'b1;
         data_parity_valid_n_oe <= 1'b0;
      end else begin
         if (take) begin
            wr_reg <= req_write;
            stream_reg <= req_stream;
            wide_reg <= req_wide && req_stream;
            wdata_hi_reg <= req_wdata_hi;
            busy <= 1'b1;
            address_latch_n <= 1'b0;
            byte_enables_n <= req_be_n;
            addr_out <= req_addr;
            addr_oe <= 1'b1;
            // Address parity is only claimed during the address portion.
            addr_parity_valid_n <= !parity_en;
            burst_n <= !req_stream; // see [RULE_17]
            // Write data goes out with the address, long before the command.
            data_out <= req_wdata; // see [RULE_11]
            data_oe <= req_write;
         end
         if (state_reg == chan_parity_pkg::ST_ADDR && timer_zero) begin
            address_latch_n <= 1'b1;
            cmd_n <= 1'b0;
            addr_parity_valid_n <= 1'b1; // see [RULE_04]
            terminal_count_n <= !tc_pend_reg; // see [RULE_15] see [RULE_21]
            if (wide_reg && wr_reg) begin
               addr_out <= wdata_hi_reg;
            end else if (wide_reg) begin
               addr_oe <= 1'b0;
            end
            // The strobe rises with the command, ADDR_CYC after the latch.
            if (wr_reg && parity_en) begin
               data_parity_valid_n_out <= 1'b0; // see [RULE_09] see [RULE_10] see [RULE_01]
               data_parity_valid_n_oe <= 1'b1;
            end
         end
         if (state_reg == chan_parity_pkg::ST_ADDR && wr_reg) begin
            data_parity_bits_out <= par_lo; // see [RULE_02] see [RULE_18]
            addr_parity_out <= par_hi; // see [RULE_04]
         end
         if (cmd_end) begin
            cmd_n <= 1'b1;
            terminal_count_n <= 1'b1;
            if (!wr_reg) begin
               addr_oe <= 1'b0;
            end
         end
         // The strobe stays active through the hold and is then driven high.
         if (state_reg == chan_parity_pkg::ST_HOLD && timer_zero && wr_reg) begin
            data_parity_valid_n_out <= 1'b1; // see [RULE_12] see [RULE_16] see [RULE_19]
         end
         if (state_reg == chan_parity_pkg::ST_HOLD && timer_zero && !wr_reg) begin
            busy <= 1'b0;
            burst_n <= 1'b1;
            byte_enables_n <= 4'hF;
         end
         if (state_reg == chan_parity_pkg::ST_RELEASE && timer_zero) begin
            data_parity_valid_n_oe <= 1'b0; // see [RULE_19]
            burst_n <= 1'b1; // see [RULE_17]
            data_oe <= 1'b0;
            addr_oe <= 1'b0;
            busy <= 1'b0;
            byte_enables_n <= 4'hF;
         end
      end
   end

   // Status toward the user; an event in the clear cycle still sets.
   logic rd_err_reg;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rd_err_reg <= 1'b0;
         read_parity_err <= 1'b0;
         check_seen <= 1'b0;
         exception_post <= 1'b0;
         done <= 1'b0;
         rdata <= '0;
         rdata_hi <= '0;
      end else begin
         if (cmd_end && !wr_reg) begin
            rdata <= data_in;
            rdata_hi <= addr_in;
            rd_err_reg <= rd_err; // see [RULE_08]
         end
         done <= (state_reg == chan_parity_pkg::ST_RELEASE && timer_zero) ||
                 (state_reg == chan_parity_pkg::ST_HOLD && timer_zero && !wr_reg);
         // The check result is used only after the recovery wait.
         exception_post <= state_reg == chan_parity_pkg::ST_HOLD && timer_zero &&
                           !wr_reg && rd_err_reg; // see [RULE_13] see [RULE_20]
         if (state_reg == chan_parity_pkg::ST_HOLD && timer_zero && !wr_reg && rd_err_reg) begin
            read_parity_err <= 1'b1; // see [RULE_20] see [RULE_21]
         end else if (status_clear) begin
            read_parity_err <= 1'b0;
         end
         if (channel_check_n_now) begin
            check_seen <= 1'b1; // see [RULE_16]
         end else if (status_clear) begin // see [RULE_23]
            check_seen <= 1'b0;
         end
      end
   end

   // Assertion helper: cycles since the address latch went active.
   logic [7:0] since_adl;

   always_ff @(posedge clk) begin
      if (sys_rst || take) begin
         since_adl <= '0;
      end else if (since_adl != 8'hFF) begin
         since_adl <= since_adl + 1'b1;
      end
   end

   a_strobe_with_cmd: assert property (@(posedge clk) disable iff (sys_rst) // see [RULE_09]
      $fell(cmd_n) && wr_reg && parity_en |-> !data_parity_valid_n_out)
      else $error("write strobe not raised with command");

   a_strobe_after_adl: assert property (@(posedge clk) disable iff (sys_rst) // see [RULE_10]
      $fell(data_parity_valid_n_out) |-> since_adl >= 8'(chan_parity_pkg::ADDR_CYC))
      else $error("write strobe too soon after address latch");

   a_data_setup: assert property (@(posedge clk) disable iff (sys_rst) // see [RULE_11]
      $fell(cmd_n) && wr_reg |-> $past(data_oe, 2))
      else $error("write data not set up before command");

   a_drive_high_first: assert property (@(posedge clk) disable iff (sys_rst) // see [RULE_19]
      $fell(data_parity_valid_n_oe) |-> $past(data_parity_valid_n_out, 1) &&
      $past(data_parity_valid_n_out, 2))
      else $error("strobe released while not driven inactive");

   a_burst_after_strobe: assert property (@(posedge clk) disable iff (sys_rst) // see [RULE_17]
      $rose(burst_n) |-> data_parity_valid_n_out)
      else $error("burst dropped before strobe inactive");

   a_disabled_quiet: assert property (@(posedge clk) disable iff (sys_rst) // see [RULE_22]
      !parity_en && state_reg == chan_parity_pkg::ST_IDLE |=> data_parity_valid_n_out)
      else $error("strobe driven while parity disabled");

   a_source_only: assert property (@(posedge clk) disable iff (sys_rst) // see [RULE_01]
      data_parity_valid_n_oe |-> wr_reg)
      else $error("strobe driven on a read");

   a_addr_strobe_off: assert property (@(posedge clk) disable iff (sys_rst) // see [RULE_04]
      !cmd_n |-> addr_parity_valid_n)
      else $error("address strobe active in data portion");

   a_stream_hold: assert property (@(posedge clk) disable iff (sys_rst) // see [RULE_16]
      $rose(cmd_n) && wr_reg && stream_reg && parity_en |->
      !data_parity_valid_n_out [*5])
      else $error("streaming strobe hold too short");

   a_read_recovery: assert property (@(posedge clk) disable iff (sys_rst) // see [RULE_13]
      $rose(cmd_n) && !wr_reg |-> !exception_post [*8])
      else $error("read check used before recovery");

   c_read: cover property (@(posedge clk) disable iff (sys_rst) done && !wr_reg);
   c_write: cover property (@(posedge clk) disable iff (sys_rst) done && wr_reg && !stream_reg);
   c_wide: cover property (@(posedge clk) disable iff (sys_rst) done && wide_reg && wr_reg);
   c_rd_err: cover property (@(posedge clk) disable iff (sys_rst) exception_post);

endmodule : parity_master

// File: testbench/slave_model.sv
`timescale 1ns/1ns

// Behavioural parity slave. The strobe line has a pull-up, and released buses
// show the inverse of their last value so that stale data never looks valid.
module slave_model (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Scenario controls
   input wire logic par_on,
   input wire logic force_chk,
   input wire logic [3:0] bad_lane,
   input wire logic [5:0] ready_wait,
   // Master drive
   input wire logic cmd_n,
   input wire logic [3:0] byte_enables_n,
   input wire logic addr_parity_valid_n,
   input wire logic [31:0] addr_out,
   input wire logic [3:0] addr_parity_out,
   input wire logic addr_oe,
   input wire logic [31:0] data_out,
   input wire logic [3:0] data_parity_bits_out,
   input wire logic data_oe,
   input wire logic dpv_m_out,
   input wire logic dpv_m_oe,
   // Resolved lines
   output logic slot_ready,
   output logic channel_check_n,
   output logic [31:0] data_bus,
   output logic [3:0] data_par,
   output logic [31:0] addr_bus,
   output logic [3:0] addr_par,
   output logic dpv_n,
   output logic status_ok
);
   logic [31:0] mem_lo, mem_hi, last_d, last_a;
   logic rd_on, dpv_drv, dpv_val, cmd_q, chk;
   logic [1:0] rel_cnt;
   logic [5:0] wait_cnt;
   logic [3:0] lo_bad, hi_bad;

   function automatic logic [3:0] par_of(input logic [31:0] w);
      for (int i = 0; i < 4; i++) begin
         par_of[i] = ^w[8*i +: 8] ^ chan_parity_pkg::PARITY_ODD;
      end
   endfunction : par_of

   assign data_bus = data_oe ? data_out : rd_on ? mem_lo : ~last_d;
   assign data_par = data_oe ? data_parity_bits_out : rd_on ? par_of(mem_lo) ^ bad_lane :
                     par_of(~last_d);
   assign addr_bus = addr_oe ? addr_out : rd_on ? mem_hi : ~last_a;
   assign addr_par = addr_oe ? addr_parity_out : rd_on ? par_of(mem_hi) : par_of(~last_a);
   assign dpv_n = dpv_m_oe ? dpv_m_out : dpv_drv ? dpv_val : 1'h1;
   assign lo_bad = (data_par ^ par_of(data_bus)) & ~byte_enables_n;
   assign hi_bad = addr_parity_valid_n ? (addr_par ^ par_of(addr_bus)) & ~byte_enables_n :
                   4'h0;
   assign chk = ~cmd_n & data_oe & ~dpv_n & par_on &
                (force_chk | (|lo_bad) | (|hi_bad));
   assign channel_check_n = ~chk;
   assign slot_ready = cmd_n | (wait_cnt >= ready_wait);

   always_ff @(posedge clk) begin
      last_d <= data_bus;
      last_a <= addr_bus;
      cmd_q <= cmd_n;
      wait_cnt <= cmd_n ? 6'h0 : wait_cnt + 6'h1;
      if (cmd_n & ~cmd_q & data_oe) begin
         mem_lo <= data_bus;
         mem_hi <= addr_bus;
      end
      if (sys_rst) begin
         rd_on <= 1'h0;
         dpv_drv <= 1'h0;
         rel_cnt <= 2'h0;
         status_ok <= 1'h1;
      end else begin
         if (chk) begin
            status_ok <= 1'h0;
         end
         if (~cmd_n & ~data_oe) begin
            rd_on <= 1'h1;
            dpv_drv <= par_on;
            dpv_val <= 1'h0;
         end else if (rd_on) begin
            rd_on <= 1'h0;
            dpv_val <= 1'h1;
            rel_cnt <= 2'h3;
         end else if (rel_cnt != 2'h0) begin
            rel_cnt <= rel_cnt - 2'h1;
            dpv_drv <= (rel_cnt != 2'h1);
         end
      end
   end
endmodule : slave_model

// File: testbench/channel_data_parity_logic_bench.sv
`timescale 1ns/1ns

module channel_data_parity_logic_bench;
   typedef struct {
      logic rd, wide;
      logic [31:0] lo, hi;
      logic rpe, post, chk, tc, par;
   } note_t;
   logic clk = 1'h0, sys_rst = 1'h1, cfg_we = 1'h0, cfg_parity_en = 1'h0, cfg_dma_mode = 1'h0;
   logic req = 1'h0, req_write = 1'h0, req_stream = 1'h0, req_wide = 1'h0, status_clear = 1'h0;
   logic [3:0] req_be_n = 4'hF, bad_lane = 4'h0, addr_parity_out, addr_parity_in;
   logic [31:0] req_addr = 32'h0, req_wdata = 32'h0, req_wdata_hi = 32'h0;
   logic busy, done, read_parity_err, check_seen, exception_post, parity_en, status_ok;
   logic address_latch_n, cmd_n, burst_n, terminal_count_n, addr_oe, addr_parity_valid_n;
   logic data_oe, data_parity_valid_n_out, data_parity_valid_n_oe, data_parity_valid_n_in;
   logic slot_ready, channel_check_n, force_chk = 1'h0, par_exp = 1'h0;
   logic [3:0] byte_enables_n, data_parity_bits_out, data_parity_bits_in;
   logic [31:0] rdata, rdata_hi, addr_out, addr_in, data_out, data_in, mem_lo, mem_hi;
   logic [5:0] ready_wait = 6'h0;
   logic exp_rpe = 1'h0, exp_chk = 1'h0, tc_due = 1'h0, tc_seen = 1'h1, dpv_used = 1'h0;
   logic p_adl = 1'h1, p_cmd = 1'h1, p_oe = 1'h0, p_out = 1'h1, p_burst = 1'h1;
   logic [35:0] p_data = 36'h0;
   int fails = 0, checks_done = 0, adl_cnt = 0, cmd_cnt = 0, hold = 0, stable = 0;
   note_t notes[$];
   note_t nt;

   parity_master i_dut (
      .clk, .sys_rst, .cfg_we, .cfg_parity_en, .cfg_dma_mode, .req, .req_write, .req_stream,
      .req_wide, .req_be_n, .req_addr, .req_wdata, .req_wdata_hi, .status_clear, .busy, .done,
      .rdata, .rdata_hi, .read_parity_err, .check_seen, .exception_post, .parity_en,
      .address_latch_n, .cmd_n, .burst_n, .terminal_count_n, .byte_enables_n, .slot_ready,
      .channel_check_n, .addr_out, .addr_parity_out, .addr_oe, .addr_in, .addr_parity_in,
      .addr_parity_valid_n, .data_out, .data_parity_bits_out, .data_oe, .data_in,
      .data_parity_bits_in, .data_parity_valid_n_out, .data_parity_valid_n_oe,
      .data_parity_valid_n_in
   );

   slave_model i_slave (
      .clk, .sys_rst, .par_on(1'h1), .force_chk, .bad_lane, .ready_wait, .cmd_n,
      .byte_enables_n, .addr_parity_valid_n, .addr_out, .addr_parity_out, .addr_oe, .data_out,
      .data_parity_bits_out, .data_oe, .dpv_m_out(data_parity_valid_n_out),
      .dpv_m_oe(data_parity_valid_n_oe), .slot_ready, .channel_check_n, .data_bus(data_in),
      .data_par(data_parity_bits_in), .addr_bus(addr_in), .addr_par(addr_parity_in),
      .dpv_n(data_parity_valid_n_in), .status_ok
   );

   initial forever #4 clk = ~clk;

   task automatic check(input logic [31:0] seen, input logic [31:0] expd);
      checks_done++;
      if (seen !== expd) begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, expd);
      end
   endtask : check

   task automatic conclude();
      if (fails == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : conclude

   task automatic setup(input logic en, input logic dma);
      cfg_parity_en = en;
      cfg_dma_mode = dma;
      cfg_we = 1'h1;
      par_exp = en;
      @(posedge clk);
      #1 cfg_we = 1'h0;
   endtask : setup

   task automatic clear();
      status_clear = 1'h1;
      exp_rpe = 1'h0;
      exp_chk = 1'h0;
      @(posedge clk);
      #1 status_clear = 1'h0;
   endtask : clear

   // Notes the expected answer, issues one transfer, waits for done.
   task automatic op(input logic wr, input logic st, input logic wd, input logic [3:0] be);
      logic err, wchk;
      err = ~wr & par_exp & (|(bad_lane & ~be));
      wchk = wr & par_exp & force_chk;
      exp_rpe |= err;
      exp_chk |= wchk;
      notes.push_back('{~wr, wd, mem_lo, mem_hi, exp_rpe, err, exp_chk, ~tc_due, wr & par_exp});
      tc_due = cfg_dma_mode & (err | wchk);
      req_write = wr;
      req_stream = st;
      req_wide = wd;
      req_be_n = be;
      req_addr = $urandom;
      req_wdata = $urandom;
      req_wdata_hi = $urandom;
      if (wr) begin
         mem_lo = req_wdata;
         mem_hi = wd ? req_wdata_hi : req_addr;
      end
      req = 1'h1;
      @(posedge clk);
      #1 req = 1'h0;
      for (int i = 0; i < 300 && done !== 1'h1; i++) begin
         @(posedge clk);
         #1;
      end
   endtask : op

   // Watches the pins; each done takes the oldest note.
   always @(posedge clk) begin
      #2;
      if (address_latch_n === 1'h0 && p_adl === 1'h1) adl_cnt = 0;
      if (cmd_n === 1'h0 && p_cmd === 1'h1) begin
         cmd_cnt = 0;
         hold = 0;
         tc_seen = terminal_count_n;
         if (data_oe === 1'h1) check(stable >= 2, 1'h1);
      end
      if (data_parity_valid_n_oe === 1'h1 && p_oe !== 1'h1) begin
         dpv_used = 1'h1;
         check(adl_cnt >= 5 && (cmd_n === 1'h1 || cmd_cnt <= 2), 1'h1);
      end
      if (data_parity_valid_n_oe === 1'h1 && data_parity_valid_n_out === 1'h1 && p_out === 1'h0)
         check(hold >= (req_stream ? 5 : 3), 1'h1);
      if (data_parity_valid_n_oe === 1'h0 && p_oe === 1'h1) check(p_out, 1'h1);
      if (burst_n === 1'h1 && !p_burst) check(data_parity_valid_n_in, 1'h1);
      if (done === 1'h1) begin
         if (notes.size() == 0) begin
            check(1'h0, 1'h1);
         end else begin
            nt = notes.pop_front();
            if (nt.rd) check(rdata, nt.lo);
            if (nt.rd && nt.wide) check(rdata_hi, nt.hi);
            check(read_parity_err, nt.rpe);
            check({busy, exception_post}, {1'h0, nt.post});
            check({check_seen, ~status_ok & nt.chk}, {nt.chk, nt.chk});
            check(tc_seen, nt.tc);
            check(dpv_used, nt.par);
         end
         dpv_used = 1'h0;
      end
      stable = ({data_out, data_parity_bits_out} !== p_data) ? 0 : stable + 1;
      if (cmd_n === 1'h1 && data_parity_valid_n_oe === 1'h1 && data_parity_valid_n_out === 1'h0)
         hold++;
      adl_cnt++;
      cmd_cnt++;
      p_data = {data_out, data_parity_bits_out};
      {p_adl, p_cmd, p_oe, p_out, p_burst} = {address_latch_n, cmd_n, data_parity_valid_n_oe,
                                               data_parity_valid_n_out, burst_n};
   end

   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      conclude();
   end

   initial begin
      logic [31:0] r;
      void'($urandom(32'h8807));
      repeat (12) @(posedge clk);
      #1;
      check({address_latch_n, cmd_n, burst_n, terminal_count_n, data_parity_valid_n_oe,
             parity_en, busy, done}, 8'hF0);
      sys_rst = 1'h0;
      // Parity off: the slave strobes, yet bad lanes go unseen.
      bad_lane = 4'hF;
      op(1'h1, 1'h0, 1'h0, 4'h0);
      op(1'h0, 1'h0, 1'h0, 4'h0);
      setup(1'h1, 1'h0);
      check(parity_en, 1'h1);
      op(1'h0, 1'h0, 1'h0, 4'h0);
      bad_lane = 4'h4;
      op(1'h0, 1'h0, 1'h0, 4'h4);
      clear();
      repeat (40) begin
         r = $urandom;
         ready_wait = r[13:8];
         bad_lane = r[19:16];
         force_chk = r[3];
         op(r[0], r[1], r[1] & r[2], r[7:4]);
         clear();
      end
      // DMA mode: an error raises terminal count on the next transfer.
      bad_lane = 4'h0;
      setup(1'h1, 1'h1);
      force_chk = 1'h1;
      op(1'h1, 1'h1, 1'h0, 4'h0);
      force_chk = 1'h0;
      op(1'h0, 1'h1, 1'h1, 4'h0);
      bad_lane = 4'h1;
      op(1'h0, 1'h0, 1'h0, 4'h0);
      bad_lane = 4'h0;
      op(1'h1, 1'h0, 1'h0, 4'h0);
      repeat (2) @(posedge clk);
      conclude();
   end
endmodule : channel_data_parity_logic_bench
